/* File: logic/asc_ctrl.sv */
// Converter sequencing, computation, threshold and register logic
`timescale 1ns/100ps
`include "asc_params.svh"
module asc_ctrl #(
  parameter int DW = 12,
  parameter int SW = 18
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              trigger,
  input  wire logic              conv_done,
  input  wire logic [DW-1:0]     conv_data,
  output asc_pkg::asc_afe_t      afe,
  output logic                   irq
);
  // ==========================================================
  // Register state
  logic [7:0]          pre_r, comp_r, thr_r;
  logic [31:0]         run_r;
  logic [15:0]         res_r, last_r, filt_r, setp_r, upper_r, lower_r;
  logic [SW-1:0]       sum_r;
  logic                wrap_r;
  logic [7:0]          tally_r, cnt_r;
  logic signed [SW:0]  dev_r;
  logic [2:0]          irq_r, mask_r;
  logic                second_r;
  asc_pkg::asc_state_t st_r;

  logic       precharge_level, invert_second_precharge, guard_start_level, dual_sample_on;
  logic       last_sample_source, sum_clear_cmd, halt_on_match, go, repeat_conversions;
  logic [2:0] shift_amount, compute_mode, deviation_formula, threshold_irq_select;
  logic [7:0] pre_len, acq_len, sample_repeat_count;
  assign precharge_level         = pre_r[7];
  assign invert_second_precharge = pre_r[6];
  assign guard_start_level       = pre_r[5];
  assign dual_sample_on          = pre_r[0];
  assign last_sample_source      = comp_r[7];
  assign shift_amount            = comp_r[6:4];
  assign sum_clear_cmd           = comp_r[3];
  assign compute_mode            = comp_r[2:0];
  assign deviation_formula       = thr_r[6:4];
  assign halt_on_match           = thr_r[3];
  assign threshold_irq_select    = thr_r[2:0];
  assign go                      = run_r[0];
  assign repeat_conversions      = run_r[1];
  assign pre_len                 = run_r[15:8];
  assign acq_len                 = run_r[23:16];
  assign sample_repeat_count     = run_r[31:24];

  // ==========================================================
  // AXI4-Lite slave
  logic        wr_fire, rd_fire;
  logic [9:0]  widx, ridx;
  logic [31:0] rd_nxt;
  logic        rd_ok;
  assign widx    = s_axi_awaddr[11:2];
  assign ridx    = s_axi_araddr[11:2];
  // Address and data taken together, so no stray half-write can be stored
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  logic wr_pre, wr_comp, wr_thr, wr_run, wr_setp, wr_lim, wr_irq, wr_mask, wr_known;
  logic [31:0] wd;
  assign wd       = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
  assign wr_pre   = wr_fire && widx == `ASC_IDX_PRE;
  assign wr_comp  = wr_fire && widx == `ASC_IDX_COMP;
  assign wr_thr   = wr_fire && widx == `ASC_IDX_THR;
  assign wr_run   = wr_fire && widx == `ASC_IDX_RUN;
  assign wr_setp  = wr_fire && widx == `ASC_IDX_SETP;
  assign wr_lim   = wr_fire && widx == `ASC_IDX_LIM;
  assign wr_irq   = wr_fire && widx == `ASC_IDX_IRQ;
  assign wr_mask  = wr_fire && widx == `ASC_IDX_MASK;
  assign wr_known = wr_pre || wr_comp || wr_thr || wr_run || wr_setp || wr_lim || wr_irq || wr_mask ||
                    widx inside {`ASC_IDX_RES, `ASC_IDX_LAST, `ASC_IDX_FILT, `ASC_IDX_SUM,
                                 `ASC_IDX_DEV, `ASC_IDX_STAT};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ASC_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (ridx)
      `ASC_IDX_PRE:  rd_nxt[7:0] = pre_r;
      `ASC_IDX_COMP: rd_nxt[7:0] = comp_r;
      `ASC_IDX_THR:  rd_nxt[7:0] = {1'b0, thr_r[6:0]};
      `ASC_IDX_RUN:  rd_nxt      = run_r;
      `ASC_IDX_RES:  rd_nxt[15:0] = res_r;
      `ASC_IDX_LAST: rd_nxt[15:0] = last_r;
      `ASC_IDX_FILT: rd_nxt[15:0] = filt_r;
      `ASC_IDX_SUM:  rd_nxt[SW-1:0] = sum_r;
      `ASC_IDX_SETP: rd_nxt[15:0] = setp_r;
      `ASC_IDX_LIM:  rd_nxt      = {lower_r, upper_r};
      `ASC_IDX_DEV:  rd_nxt      = 32'(dev_r);
      `ASC_IDX_IRQ:  rd_nxt[2:0] = irq_r;
      `ASC_IDX_MASK: rd_nxt[2:0] = mask_r;
      `ASC_IDX_STAT: rd_nxt      = {20'h0_0000, 1'b0, 3'(st_r), tally_r};
      default:       rd_ok       = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ASC_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_nxt;
        s_axi_rresp  <= rd_ok ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Computation (evaluated during the one-cycle deviation_formula state)
  logic [15:0]        sample, filt_nxt;
  logic [SW:0]        sum_ext;
  logic [SW-1:0]      sum_nxt;
  logic [7:0]         tally_nxt;
  logic               avg_mode, batch_done, thr_eval, thr_hit, mode_ok;
  logic signed [SW:0] dev_nxt, up_s, lo_s, diff_s;
  assign sample   = 16'(conv_data);
  assign avg_mode = compute_mode == `ASC_MD_AVG || compute_mode == `ASC_MD_BURST;
  assign up_s     = (SW+1)'(signed'(upper_r));
  assign lo_s     = (SW+1)'(signed'(lower_r));

  always_comb begin
    mode_ok   = 1'b1;
    sum_ext   = {1'b0, sum_r};
    tally_nxt = (tally_r == 8'hff) ? tally_r : tally_r + 8'h01;
    case (compute_mode)
      `ASC_MD_BASIC: begin
        tally_nxt = tally_r;
      end
      `ASC_MD_ACCUM, `ASC_MD_AVG, `ASC_MD_BURST: begin
        sum_ext = {1'b0, sum_r} + (SW+1)'(sample);
      end
      `ASC_MD_LPF: begin
        sum_ext = {1'b0, sum_r - (sum_r >> shift_amount)} + (SW+1)'(sample);
      end
      default: begin
        mode_ok   = 1'b0;
        tally_nxt = tally_r;
      end
    endcase
    sum_nxt    = sum_ext[SW-1:0];
    batch_done = avg_mode && tally_nxt >= sample_repeat_count;
    filt_nxt   = filt_r;
    if (compute_mode != `ASC_MD_BASIC && mode_ok) begin
      filt_nxt = 16'(sum_nxt >> shift_amount);
    end
    thr_eval = !avg_mode || batch_done;
  end

  always_comb begin
    diff_s = dual_sample_on ? (SW+1)'(res_r) - (SW+1)'(last_r) : (SW+1)'(res_r);
    case (deviation_formula)
      `ASC_DEVIATION_FORMULA_DIFF:  dev_nxt = (SW+1)'(res_r) - (SW+1)'(last_r);
      `ASC_DEVIATION_FORMULA_SETP:  dev_nxt = diff_s - (SW+1)'(setp_r);
      `ASC_DEVIATION_FORMULA_FILT:  dev_nxt = diff_s - (SW+1)'(filt_nxt);
      `ASC_DEVIATION_FORMULA_PREVF: dev_nxt = (SW+1)'(last_r) - (SW+1)'(filt_nxt);
      `ASC_DEVIATION_FORMULA_FSETP: dev_nxt = (SW+1)'(filt_nxt) - (SW+1)'(setp_r);
      default:         dev_nxt = '0;
    endcase
    case (threshold_irq_select)
      3'h7:    thr_hit = 1'b1;
      3'h6:    thr_hit = dev_nxt > up_s;
      3'h5:    thr_hit = dev_nxt <= up_s;
      3'h4:    thr_hit = dev_nxt < lo_s || dev_nxt > up_s;
      3'h3:    thr_hit = dev_nxt > lo_s && dev_nxt < up_s;
      3'h2:    thr_hit = dev_nxt >= lo_s;
      3'h1:    thr_hit = dev_nxt < lo_s;
      default: thr_hit = 1'b0;
    endcase
    thr_hit = thr_hit && thr_eval;
  end

  // ==========================================================
  // Sequencer
  logic in_deviation_formula, sw_abort, hw_stop, start_conv;
  assign in_deviation_formula    = st_r == asc_pkg::ST_DEVIATION_FORMULA;
  assign sw_abort   = wr_run && s_axi_wstrb[0] && !s_axi_wdata[0] && st_r != asc_pkg::ST_IDLE;
  assign hw_stop    = in_deviation_formula && !(repeat_conversions && !(halt_on_match && thr_hit));
  assign start_conv = st_r == asc_pkg::ST_IDLE && go;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r     <= asc_pkg::ST_IDLE;
      second_r <= 1'b0;
      cnt_r    <= 8'h00;
    end else if (sw_abort) begin
      st_r     <= asc_pkg::ST_IDLE;
      second_r <= 1'b0;
    end else begin
      case (st_r)
        asc_pkg::ST_IDLE: if (go) begin
          st_r  <= asc_pkg::ST_PRE;
          cnt_r <= pre_len;
        end
        asc_pkg::ST_PRE: if (cnt_r <= 8'h01) begin
          st_r  <= asc_pkg::ST_ACQ;
          cnt_r <= acq_len;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        asc_pkg::ST_ACQ: if (cnt_r <= 8'h01) begin
          st_r <= asc_pkg::ST_CONV;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        asc_pkg::ST_CONV: if (conv_done) begin
          if (dual_sample_on && !second_r) begin
            st_r     <= asc_pkg::ST_PRE;
            second_r <= 1'b1;
            cnt_r    <= pre_len;
          end else begin
            st_r     <= asc_pkg::ST_DEVIATION_FORMULA;
          end
        end
        asc_pkg::ST_DEVIATION_FORMULA: begin
          st_r     <= asc_pkg::ST_IDLE;
          second_r <= 1'b0;
        end
        default: st_r <= asc_pkg::ST_IDLE;
      endcase
    end
  end

  // Polarity flip applies only to the second half of a double sample
  logic flip;
  assign flip = second_r && dual_sample_on && invert_second_precharge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afe <= '0;
    end else begin
      afe.short_en   <= (st_r == asc_pkg::ST_IDLE && go || st_r == asc_pkg::ST_PRE && cnt_r > 8'h01) &&
                        pre_len != 8'h00;
      afe.short_high <= precharge_level ^ flip;
      afe.guard_high <= guard_start_level ^ flip;
      afe.conv_start <= st_r == asc_pkg::ST_ACQ && cnt_r <= 8'h01;
      afe.stage      <= 3'(st_r);
    end
  end

  // ==========================================================
  // Data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_r  <= 16'h0000;
      last_r <= 16'h0000;
      filt_r <= 16'h0000;
      dev_r  <= '0;
    end else begin
      if (start_conv) begin
        last_r <= last_sample_source ? filt_r : res_r;
      end
      if (st_r == asc_pkg::ST_CONV && conv_done && dual_sample_on && !second_r) begin
        last_r <= sample;
      end
      if (st_r == asc_pkg::ST_CONV && conv_done || sw_abort) begin
        res_r <= sample;
      end
      if (in_deviation_formula) begin
        filt_r <= filt_nxt;
        dev_r  <= dev_nxt;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || sum_clear_cmd) begin
      sum_r   <= '0;
      tally_r <= 8'h00;
      wrap_r  <= 1'b0;
    end else if (in_deviation_formula && mode_ok && compute_mode != `ASC_MD_BASIC) begin
      sum_r   <= batch_done ? '0 : sum_nxt;
      tally_r <= batch_done ? 8'h00 : tally_nxt;
      wrap_r  <= wrap_r | sum_ext[SW];
    end
  end

  // ==========================================================
  // Control registers; hardware stop wins over a same-cycle write of go
  logic [31:0] setp_m;
  assign setp_m = merge({16'h0000, setp_r}, s_axi_wdata, s_axi_wstrb);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r   <= `ASC_RST_PRE;
      comp_r  <= `ASC_RST_COMP;
      thr_r   <= `ASC_RST_THR;
      run_r   <= `ASC_RST_RUN;
      setp_r  <= 16'h0000;
      upper_r <= 16'h0000;
      lower_r <= 16'h0000;
      mask_r  <= 3'h0;
    end else begin
      if (wr_pre && s_axi_wstrb[0]) pre_r <= {wd[7:5], 4'h0, wd[0]};
      if (wr_thr && s_axi_wstrb[0]) thr_r <= {1'b0, wd[6:0]};
      if (wr_comp && s_axi_wstrb[0]) begin
        comp_r <= wd[7:0];
      end else if (sum_clear_cmd) begin
        comp_r[3] <= 1'b0;
      end
      if (wr_run) run_r <= merge(run_r, s_axi_wdata, s_axi_wstrb);
      if (trigger && st_r == asc_pkg::ST_IDLE) run_r[0] <= 1'b1;
      if (hw_stop) run_r[0] <= 1'b0;
      if (wr_setp) setp_r <= setp_m[15:0];
      if (wr_lim) {lower_r, upper_r} <= merge({lower_r, upper_r}, s_axi_wdata, s_axi_wstrb);
      if (wr_mask && s_axi_wstrb[0]) mask_r <= wd[2:0];
    end
  end

  // ==========================================================
  // Interrupts: sticky, write one to clear, set beats clear
  logic [2:0] irq_set;
  assign irq_set = {wrap_r, in_deviation_formula && thr_hit, in_deviation_formula};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 3'h0;
      irq   <= 1'b0;
    end else begin
      irq_r <= (irq_r & ~(wr_irq && s_axi_wstrb[0] ? wd[2:0] : 3'h0)) | irq_set;
      irq   <= |(((irq_r & ~(wr_irq && s_axi_wstrb[0] ? wd[2:0] : 3'h0)) | irq_set) & mask_r);
    end
  end

  // ==========================================================
  // Checks
  a_halt_stops_go: assert property (@(posedge aclk) disable iff (!aresetn)
    in_deviation_formula && repeat_conversions && halt_on_match && thr_hit && !sw_abort |=> !go)
    else $error("go still set after halting match");
  a_single_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    in_deviation_formula && !repeat_conversions |=> !go && st_r == asc_pkg::ST_IDLE)
    else $error("single trigger did not clear go");
  a_abort_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_abort |=> st_r == asc_pkg::ST_IDLE && !irq_r[`ASC_IRQ_DONE] || $past(irq_r[0]))
    else $error("abort did not reset sequencer");
  a_clear_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    sum_clear_cmd && !(wr_comp && s_axi_wstrb[0])
    |=> sum_r == '0 && tally_r == 8'h00 && !wrap_r && !sum_clear_cmd)
    else $error("sum clear incomplete");
  a_flip_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == asc_pkg::ST_PRE && second_r && dual_sample_on && invert_second_precharge && $stable(pre_r)
    |=> afe.short_high == !precharge_level && afe.guard_high == !guard_start_level)
    else $error("second precharge not inverted");
  a_no_short: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_len == 8'h00 && $stable(pre_len) |=> !afe.short_en)
    else $error("precharge short with zero length");
  a_thr_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    in_deviation_formula && thr_hit |=> irq_r[`ASC_IRQ_THR])
    else $error("threshold flag missing");
  a_basic_filt: assert property (@(posedge aclk) disable iff (!aresetn)
    in_deviation_formula && compute_mode == `ASC_MD_BASIC && !sum_clear_cmd |=> $stable(filt_r) && $stable(tally_r))
    else $error("basic mode changed filter state");
  a_dual_prev: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == asc_pkg::ST_CONV && conv_done && dual_sample_on && !second_r && !sw_abort
    |=> last_r == $past(sample) ##1 st_r == asc_pkg::ST_PRE || st_r == asc_pkg::ST_ACQ)
    else $error("first sample not kept");
  a_irq_out: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> irq == |(irq_r & $past(mask_r)))
    else $error("interrupt output mismatch");
endmodule : asc_ctrl

/* File: logic/asc_params.svh */
// Register indices, field positions, codes and reset values of the converter control block
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
`define ASC_IDX_PRE      10'h112
`define ASC_IDX_COMP     10'h113
`define ASC_IDX_THR      10'h114
`define ASC_IDX_RUN      10'h120
`define ASC_IDX_RES      10'h121
`define ASC_IDX_LAST     10'h122
`define ASC_IDX_FILT     10'h123
`define ASC_IDX_SUM      10'h124
`define ASC_IDX_SETP     10'h125
`define ASC_IDX_LIM      10'h126
`define ASC_IDX_DEV      10'h127
`define ASC_IDX_IRQ      10'h128
`define ASC_IDX_MASK     10'h129
`define ASC_IDX_STAT     10'h12a
`define ASC_RST_PRE      8'h00
`define ASC_RST_COMP     8'h00
`define ASC_RST_THR      8'h00
`define ASC_RST_RUN      32'h0000_0000
`define ASC_MD_BASIC     3'h0
`define ASC_MD_ACCUM     3'h1
`define ASC_MD_AVG       3'h2
`define ASC_MD_BURST     3'h3
`define ASC_MD_LPF       3'h4
`define ASC_DEVIATION_FORMULA_DIFF    3'h0
`define ASC_DEVIATION_FORMULA_SETP    3'h1
`define ASC_DEVIATION_FORMULA_FILT    3'h2
`define ASC_DEVIATION_FORMULA_PREVF   3'h4
`define ASC_DEVIATION_FORMULA_FSETP   3'h5
`define ASC_IRQ_DONE     0
`define ASC_IRQ_THR      1
`define ASC_IRQ_WRAP     2
`define ASC_RESP_OKAY    2'h0
`define ASC_RESP_SLVERR  2'h2
`endif

/* File: logic/asc_pkg.sv */
// Types shared by the converter control block
package asc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV, ST_DEVIATION_FORMULA} asc_state_t;
  typedef struct packed {
    logic       short_en;
    logic       short_high;
    logic       guard_high;
    logic       conv_start;
    logic [2:0] stage;
  } asc_afe_t;
endpackage : asc_pkg

/* File: sim/test_adc_sequence_compute_control.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/100ps
`include "asc_params.svh"
module test_adc_sequence_compute_control;
  logic                aclk;
  logic                aresetn;
  logic [11:0]         s_axi_awaddr;
  logic                s_axi_awvalid;
  logic                s_axi_awready;
  logic [31:0]         s_axi_wdata;
  logic [3:0]          s_axi_wstrb;
  logic                s_axi_wvalid;
  logic                s_axi_wready;
  logic [1:0]          s_axi_bresp;
  logic                s_axi_bvalid;
  logic                s_axi_bready;
  logic [11:0]         s_axi_araddr;
  logic                s_axi_arvalid;
  logic                s_axi_arready;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_rresp;
  logic                s_axi_rvalid;
  logic                s_axi_rready;
  logic                trigger;
  logic                conv_done;
  logic [11:0]         conv_data;
  asc_pkg::asc_afe_t   afe;
  logic                irq;
  logic [33:0]         exp_q[$];
  logic [1:0]          bexp_q[$];
  logic [11:0]         d0;
  logic [11:0]         d1;
  int                  failures;
  int                  compares;
  int                  seed_val;

  asc_ctrl i_asc_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .trigger(trigger), .conv_done(conv_done), .conv_data(conv_data), .afe(afe), .irq(irq));

  // ==========================================
  // Clock, comparison and closing
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] expd);
    compares++;
    if (seen !== expd) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Read answers are matched against the oldest note
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      if (exp_q.size() == 0) check({s_axi_rresp, s_axi_rdata}, 34'h3_ffff_ffff);
      else check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      if (bexp_q.size() == 0) check({32'h0, s_axi_bresp}, 34'h3_ffff_ffff);
      else check({32'h0, s_axi_bresp}, {32'h0, bexp_q.pop_front()});
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop;
  end

  // ==========================================
  // Bus and converter tasks
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] rs = `ASC_RESP_OKAY);
    bexp_q.push_back(rs);
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // The note is queued before the request goes out
  task automatic rd(input logic [9:0] idx, input logic [1:0] rs, input logic [31:0] d);
    exp_q.push_back({rs, d});
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic conv(input logic [11:0] d, input logic hi, input logic g);
    int n;
    n = 0;
    while (!afe.short_en && n < 100) begin
      @(posedge aclk);
      n++;
    end
    check({32'h0, afe.short_high, afe.guard_high}, {32'h0, hi, g});
    while (!afe.conv_start && n < 200) begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, afe.stage}, 34'h2);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
    if (n >= 200) failures++;
  endtask : conv

  // ==========================================
  // Main sequence
  initial begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, trigger, conv_done, conv_data} = '0;
    s_axi_wstrb = 4'hf;
    failures = 0;
    compares = 0;
    seed_val = $urandom(32'h734fc4de);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ASC_IDX_PRE, `ASC_RESP_OKAY, 32'h0);
    rd(`ASC_IDX_COMP, `ASC_RESP_OKAY, 32'h0);
    rd(`ASC_IDX_THR, `ASC_RESP_OKAY, 32'h0);
    rd(`ASC_IDX_RUN, `ASC_RESP_OKAY, 32'h0);
    rd(10'h200, `ASC_RESP_SLVERR, 32'h0);
    wr(10'h200, 32'h0, `ASC_RESP_SLVERR);
    $display("Test reset values finished");
    // Basic mode with a nonzero shift that must be ignored
    d0 = 12'($urandom);
    d1 = 12'($urandom);
    wr(`ASC_IDX_COMP, 32'h70);
    wr(`ASC_IDX_THR, 32'h17);
    wr(`ASC_IDX_SETP, 32'h800);
    wr(`ASC_IDX_RUN, 32'h0002_0201);
    conv(d0, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    wr(`ASC_IDX_RUN, 32'h0002_0201);
    conv(d1, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    rd(`ASC_IDX_RES, `ASC_RESP_OKAY, {20'h0, d1});
    rd(`ASC_IDX_LAST, `ASC_RESP_OKAY, {20'h0, d0});
    rd(`ASC_IDX_DEV, `ASC_RESP_OKAY, 32'(int'(d1) - 2048));
    rd(`ASC_IDX_IRQ, `ASC_RESP_OKAY, 32'h3);
    wr(`ASC_IDX_MASK, 32'h2);
    repeat (3) @(posedge aclk);
    check({33'h0, irq}, 34'h1);
    wr(`ASC_IDX_IRQ, 32'h2);
    repeat (3) @(posedge aclk);
    check({33'h0, irq}, 34'h0);
    rd(`ASC_IDX_IRQ, `ASC_RESP_OKAY, 32'h1);
    $display("Test basic conversion and interrupt finished");
    // Dual sampling, second precharge inverted
    d0 = 12'($urandom);
    d1 = 12'($urandom);
    wr(`ASC_IDX_PRE, 32'he1);
    wr(`ASC_IDX_COMP, 32'h00);
    wr(`ASC_IDX_THR, 32'h00);
    wr(`ASC_IDX_RUN, 32'h0002_0201);
    conv(d0, 1'b1, 1'b1);
    conv(d1, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    rd(`ASC_IDX_PRE, `ASC_RESP_OKAY, 32'he1);
    rd(`ASC_IDX_LAST, `ASC_RESP_OKAY, {20'h0, d0});
    rd(`ASC_IDX_RES, `ASC_RESP_OKAY, {20'h0, d1});
    rd(`ASC_IDX_DEV, `ASC_RESP_OKAY, 32'(int'(d1) - int'(d0)));
    $display("Test dual sampling finished");
    // Accumulate by trigger, then clear the sum
    wr(`ASC_IDX_PRE, 32'h00);
    wr(`ASC_IDX_COMP, 32'h29);
    wr(`ASC_IDX_RUN, 32'h0002_0200);
    d0 = 12'($urandom);
    d1 = 12'($urandom);
    for (int i = 0; i < 2; i++) begin
      trigger <= 1'b1;
      @(posedge aclk);
      trigger <= 1'b0;
      conv(i == 0 ? d0 : d1, 1'b0, 1'b0);
      repeat (4) @(posedge aclk);
    end
    rd(`ASC_IDX_SUM, `ASC_RESP_OKAY, 32'(int'(d0) + int'(d1)));
    rd(`ASC_IDX_FILT, `ASC_RESP_OKAY, 32'((int'(d0) + int'(d1)) / 4));
    wr(`ASC_IDX_COMP, 32'h29);
    repeat (3) @(posedge aclk);
    rd(`ASC_IDX_COMP, `ASC_RESP_OKAY, 32'h21);
    rd(`ASC_IDX_SUM, `ASC_RESP_OKAY, 32'h0);
    rd(`ASC_IDX_STAT, `ASC_RESP_OKAY, 32'h0);
    $display("Test accumulate and clear finished");
    // Average of two samples, then low-pass over the same pair
    d0 = 12'($urandom);
    d1 = 12'($urandom);
    wr(`ASC_IDX_THR, 32'h0f);
    wr(`ASC_IDX_RUN, 32'h0202_0200);
    for (int m = 0; m < 2; m++) begin
      wr(`ASC_IDX_COMP, m == 0 ? 32'h12 : 32'h14);
      for (int i = 0; i < 2; i++) begin
        trigger <= 1'b1;
        @(posedge aclk);
        trigger <= 1'b0;
        conv(i == 0 ? d0 : d1, 1'b0, 1'b0);
        repeat (4) @(posedge aclk);
      end
      if (m == 0) rd(`ASC_IDX_FILT, `ASC_RESP_OKAY, 32'((int'(d0) + int'(d1)) / 2));
      else rd(`ASC_IDX_FILT, `ASC_RESP_OKAY, 32'((int'(d0) - int'(d0) / 2 + int'(d1)) / 2));
    end
    $display("Test average and filter finished");
    // Continuous run stopped by a threshold match
    wr(`ASC_IDX_RUN, 32'h0002_0203);
    conv(d0, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    rd(`ASC_IDX_RUN, `ASC_RESP_OKAY, 32'h0002_0202);
    $display("Test continuous halt finished");
    // Software abort keeps the partial result and raises no flag
    wr(`ASC_IDX_COMP, 32'h00);
    wr(`ASC_IDX_IRQ, 32'h7);
    conv_data <= 12'($urandom);
    wr(`ASC_IDX_RUN, 32'h0008_0801);
    wr(`ASC_IDX_RUN, 32'h0);
    repeat (4) @(posedge aclk);
    rd(`ASC_IDX_RES, `ASC_RESP_OKAY, {20'h0, conv_data});
    rd(`ASC_IDX_IRQ, `ASC_RESP_OKAY, 32'h0);
    $display("Test abort finished");
    repeat (4) @(posedge aclk);
    report_and_stop;
  end
endmodule : test_adc_sequence_compute_control
